//--- hbcfg_pkg.sv
package hbcfg_pkg;

    // -------------------------------------------------------------
    // Configuration dword addresses (byte address, bits 1:0 zero)
    // -------------------------------------------------------------
    localparam logic [7:0] HBCFG_DW_LATHDR = 8'h0c; // Holds 0x0d and 0x0e
    localparam logic [7:0] HBCFG_DW_APERTURE_BASE_ADDRESS = 8'h10;
    localparam logic [7:0] HBCFG_DW_SUBSYS = 8'h2c;

    // Printed byte offsets of the byte-wide registers
    localparam logic [7:0] HBCFG_OFS_LATENCY = 8'h0d;
    localparam logic [7:0] HBCFG_OFS_HEADER = 8'h0e;

    // -------------------------------------------------------------
    // Aperture base field layout and fixed values
    // -------------------------------------------------------------
    localparam int HBCFG_AB_UPPER_LSB = 26;
    localparam int HBCFG_AB_SIZE_BIT = 25;
    localparam int HBCFG_AB_PREF_BIT = 3;
    localparam logic [5:0] HBCFG_AB_UPPER_RST = 6'h00;
    localparam logic HBCFG_AB_BIT25_RST = 1'b0;
    localparam logic [31:0] HBCFG_AB_RST_AGP = 32'h00000008;
    localparam logic [31:0] HBCFG_AB_RST_GFX = 32'h00000000;

    // Fixed read values of the byte-wide registers
    localparam logic [7:0] HBCFG_LATENCY_VAL = 8'h00;
    localparam logic [7:0] HBCFG_HEADER_VAL = 8'h00;

    // Subsystem maker identifier reset value
    localparam logic [15:0] HBCFG_SUBSYS_RST = 16'h0000;

    // Strap settle count before the graphics mode strap is caught
    localparam logic [1:0] HBCFG_STRAP_SETTLE = 2'h3;

    // -------------------------------------------------------------
    // Configuration request carrier
    // -------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } hbcfg_req_s;

endpackage

//--- hbcfg_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Latency timer byte reads zero, every write to it is ignored.
// RULE2 - Header layout byte has no storage; reads zero, writes do nothing.
// RULE3 - Aperture base resets to 0x00000008, or all zero in integrated graphics mode.
// RULE4 - Aperture base bits 31:26 are read/write and reset to zero.
// RULE5 - With size control clear, base bit 25 reads zero as if hardwired.
// RULE6 - With size control set, base bit 25 is read/write for 32 MB placement.
// RULE7 - Aperture base bits 24:4 always read zero and cannot be written.
// RULE8 - Aperture base bit 3 reads one: aperture is prefetchable. The code reads it as zero in integrated graphics mode.
// RULE9 - Aperture base bits 2:1 read 00: anywhere in 32-bit space.
// RULE10 - Aperture base bit 0 reads zero: a memory range.
// RULE11 - An access control bit blocks all aperture hits until software enables it.
// RULE12 - Firmware picks a smaller aperture before generic software sizes the base.
// RULE13 - Subsystem maker identifier resets to 0x0000.
// RULE14 - Subsystem maker identifier takes one write, then turns read-only.
// RULE15 - Only reset clears the identifier and its write lock.
// RULE16 - Boot firmware programs the identifier early; later writes are lost.
// RULE17 - Aperture base writes change only bits that are programmable right now.
module hbcfg_regs
    import hbcfg_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Configuration access
    input wire hbcfg_req_s CFG_REQ,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    // Back-end controls from neighbouring registers
    input wire logic APER_SIZE_CTRL,
    input wire logic APER_ACCESS_EN,
    // Integrated graphics mode strap pin
    input wire logic INTEGRATED_GRAPHICS_MODE_STRAP,
    // Aperture decode
    input wire logic MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    output logic APER_HIT
);

    // ---------------------------------------------------------------
    // Strap synchroniser and capture
    // ---------------------------------------------------------------
    logic strap1_ff, strap2_ff, strap3_ff;
    logic [1:0] settle_ff;
    logic integrated_graphics_mode_ff;
    logic gfx_known_ff;
    wire strap_agree = (strap2_ff == strap3_ff);
    wire strap_take = !gfx_known_ff && strap_agree && (settle_ff == HBCFG_STRAP_SETTLE);

    // The strap is caught after release; a reset flop may only take constants
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            strap1_ff <= 1'b0;
            strap2_ff <= 1'b0;
            strap3_ff <= 1'b0;
            settle_ff <= 2'h0;
            integrated_graphics_mode_ff <= 1'b0;
            gfx_known_ff <= 1'b0;
        end
        else
        begin
            strap1_ff <= INTEGRATED_GRAPHICS_MODE_STRAP;
            strap2_ff <= strap1_ff;
            strap3_ff <= strap2_ff;
            if (settle_ff != HBCFG_STRAP_SETTLE)
                settle_ff <= settle_ff + 2'h1;
            if (strap_take)
            begin
                integrated_graphics_mode_ff <= strap3_ff;
                gfx_known_ff <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire hit_lathdr = (CFG_REQ.addr == HBCFG_DW_LATHDR);
    wire hit_aperture_base_address = (CFG_REQ.addr == HBCFG_DW_APERTURE_BASE_ADDRESS);
    wire hit_subsys = (CFG_REQ.addr == HBCFG_DW_SUBSYS);
    wire wr_aperture_base_address = CFG_REQ.wr && hit_aperture_base_address;
    wire wr_subsys = CFG_REQ.wr && hit_subsys;

    // ---------------------------------------------------------------
    // Aperture base storage
    // ---------------------------------------------------------------
    logic [5:0] ab_upper_ff;
    logic ab_bit25_ff;
    logic [5:0] nxt_ab_upper;
    logic nxt_ab_bit25;

    // Only the top byte lane carries programmable bits [RULE17]
    assign nxt_ab_upper = (wr_aperture_base_address && CFG_REQ.be[3]) ?
        CFG_REQ.wdata[31:HBCFG_AB_UPPER_LSB] : ab_upper_ff; // [RULE4]
    // Bit 25 is forced back to zero while the size control is clear
    assign nxt_ab_bit25 = !APER_SIZE_CTRL ? 1'b0 :
        ((wr_aperture_base_address && CFG_REQ.be[3]) ? CFG_REQ.wdata[HBCFG_AB_SIZE_BIT] : ab_bit25_ff); // [RULE5] [RULE6]

    // Upper base bits and bit 25
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ab_upper_ff <= HBCFG_AB_UPPER_RST; // [RULE4]
            ab_bit25_ff <= HBCFG_AB_BIT25_RST;
        end
        else
        begin
            ab_upper_ff <= nxt_ab_upper;
            ab_bit25_ff <= nxt_ab_bit25;
        end
    end

    // Read view: 24:4 zero, 3 prefetchable, 2:1 type 00, 0 memory [RULE7] [RULE9] [RULE10]
    // Prefetchable reads as one except in integrated graphics mode [RULE3] [RULE8]
    wire ab_pref = !integrated_graphics_mode_ff;
    wire [31:0] ab_view = {ab_upper_ff, ab_bit25_ff & APER_SIZE_CTRL, 21'h0,
        ab_pref, 3'h0};

    // ---------------------------------------------------------------
    // Subsystem maker identifier, write once
    // ---------------------------------------------------------------
    logic [15:0] subsys_ff;
    logic subsys_lock_ff;
    logic [15:0] nxt_subsys;
    wire subsys_take = wr_subsys && !subsys_lock_ff && (CFG_REQ.be[1:0] != 2'h0);

    // Byte lanes merge on the single accepted write [RULE14]
    assign nxt_subsys = {
        (subsys_take && CFG_REQ.be[1]) ? CFG_REQ.wdata[15:8] : subsys_ff[15:8],
        (subsys_take && CFG_REQ.be[0]) ? CFG_REQ.wdata[7:0] : subsys_ff[7:0]};

    // Lock has no software clear; reset is the only way back [RULE15]
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            subsys_ff <= HBCFG_SUBSYS_RST; // [RULE13]
            subsys_lock_ff <= 1'b0;
        end
        else
        begin
            subsys_ff <= nxt_subsys;
            if (subsys_take)
                subsys_lock_ff <= 1'b1; // [RULE14]
        end
    end

    // ---------------------------------------------------------------
    // Read data path
    // ---------------------------------------------------------------
    // Latency and header bytes have no flops: constants only [RULE1] [RULE2]
    wire [31:0] lathdr_view = {8'h00, HBCFG_HEADER_VAL, HBCFG_LATENCY_VAL, 8'h00};
    wire [31:0] rd_mux = hit_lathdr ? lathdr_view :
        hit_aperture_base_address ? ab_view :
        hit_subsys ? {16'h0000, subsys_ff} : 32'h00000000;

    // Whole dword returned; unmapped dwords read zero
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CFG_RDATA <= 32'h00000000;
            CFG_RVALID <= 1'b0;
        end
        else
        begin
            CFG_RVALID <= CFG_REQ.rd;
            if (CFG_REQ.rd)
                CFG_RDATA <= rd_mux;
        end
    end

    // ---------------------------------------------------------------
    // Aperture decode
    // ---------------------------------------------------------------
    // Bit 25 only compares in the 32 MB setting
    wire ap_match = (MEM_ADDR[31:26] == ab_upper_ff) &&
        (!APER_SIZE_CTRL || (MEM_ADDR[25] == ab_bit25_ff));
    // Gate keeps stale or unset bases from claiming cycles [RULE11]
    wire nxt_hit = MEM_REQ && APER_ACCESS_EN && ap_match;

    // Registered hit, one cycle after the request
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            APER_HIT <= 1'b0;
        else
            APER_HIT <= nxt_hit;
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [7:0] rd_addr_ff;
    logic ab_written_ff;

    // Helper state for the checks only
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_addr_ff <= 8'h00;
            ab_written_ff <= 1'b0;
        end
        else
        begin
            if (CFG_REQ.rd)
                rd_addr_ff <= CFG_REQ.addr;
            if (wr_aperture_base_address)
                ab_written_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_read_of(logic [7:0] a);
        CFG_REQ.rd && (CFG_REQ.addr == a);
    endsequence

    sequence s_top_write;
        wr_aperture_base_address && CFG_REQ.be[3] && !CFG_REQ.rd;
    endsequence

    a_latency_reads_zero: assert property (s_read_of(HBCFG_DW_LATHDR) |=> // [RULE1]
        CFG_RVALID && (CFG_RDATA[15:8] == 8'h00))
        else $error("latency byte did not read zero");

    a_header_reads_zero: assert property (s_read_of(HBCFG_DW_LATHDR) |=> // [RULE2]
        CFG_RDATA[23:16] == 8'h00)
        else $error("header byte did not read zero");

    a_base_default_value: assert property (s_read_of(HBCFG_DW_APERTURE_BASE_ADDRESS) and // [RULE3]
        (!ab_written_ff && gfx_known_ff) |=>
        CFG_RDATA == ($past(integrated_graphics_mode_ff) ? HBCFG_AB_RST_GFX : HBCFG_AB_RST_AGP))
        else $error("aperture base default wrong");

    a_upper_bits_write: assert property (s_top_write ##1 s_read_of(HBCFG_DW_APERTURE_BASE_ADDRESS) |=> // [RULE4]
        CFG_RDATA[31:26] == $past(CFG_REQ.wdata[31:26], 2))
        else $error("upper base bits not written");

    a_bit25_hardwired: assert property (s_read_of(HBCFG_DW_APERTURE_BASE_ADDRESS) and (!APER_SIZE_CTRL) |=> // [RULE5]
        !CFG_RDATA[25])
        else $error("bit 25 not zero in 64 MB setting");

    a_bit25_writable: assert property ((s_top_write and APER_SIZE_CTRL) ##1 APER_SIZE_CTRL // [RULE6]
        |-> ab_bit25_ff == $past(CFG_REQ.wdata[25]))
        else $error("bit 25 not written in 32 MB setting");

    a_fixed_low_bits: assert property (CFG_RVALID && rd_addr_ff == HBCFG_DW_APERTURE_BASE_ADDRESS // [RULE7]
        |-> CFG_RDATA[24:4] == 21'h000000 && CFG_RDATA[2:0] == 3'h0)
        else $error("fixed aperture bits disturbed");

    a_prefetch_bit: assert property (s_read_of(HBCFG_DW_APERTURE_BASE_ADDRESS) and // [RULE8]
        (gfx_known_ff && !integrated_graphics_mode_ff) |=> CFG_RDATA[3])
        else $error("prefetchable bit not one");

    a_access_blocked: assert property (!APER_ACCESS_EN |=> !APER_HIT) // [RULE11]
        else $error("aperture hit while access blocked");

    a_ident_reset_zero: assert property (!subsys_lock_ff |-> subsys_ff == 16'h0000) // [RULE13]
        else $error("identifier changed without a write");

    a_ident_write_once: assert property (subsys_lock_ff && wr_subsys |=> // [RULE14]
        $stable(subsys_ff))
        else $error("identifier changed after lock");

    a_ident_lock_holds: assert property (subsys_lock_ff |=> subsys_lock_ff) // [RULE15]
        else $error("identifier lock cleared without reset");

    // Fixed type and space bits, checked on each aperture base read
    a_type_bits_zero: assert property (CFG_RVALID && rd_addr_ff == HBCFG_DW_APERTURE_BASE_ADDRESS // [RULE9]
        |-> CFG_RDATA[2:1] == 2'h0)
        else $error("aperture type bits not zero");

    a_memory_space_bit: assert property (CFG_RVALID && rd_addr_ff == HBCFG_DW_APERTURE_BASE_ADDRESS // [RULE10]
        |-> !CFG_RDATA[0])
        else $error("aperture space bit not zero");

    // A write without the top lane must leave the base alone
    a_masked_write_kept: assert property (wr_aperture_base_address && !CFG_REQ.be[3] |=> // [RULE17]
        $stable(ab_upper_ff))
        else $error("base moved on a masked write");

    a_bit25_cleared: assert property (!APER_SIZE_CTRL |=> !ab_bit25_ff) // [RULE5]
        else $error("bit 25 storage kept in 64 MB setting");

    a_access_hit: assert property (MEM_REQ && APER_ACCESS_EN && !APER_SIZE_CTRL // [RULE11]
        && MEM_ADDR[31:26] == ab_upper_ff |=> APER_HIT)
        else $error("enabled aperture cycle missed");

    a_ident_first_write: assert property (wr_subsys && !subsys_lock_ff // [RULE14]
        && CFG_REQ.be[0] |=> subsys_ff[7:0] == $past(CFG_REQ.wdata[7:0]))
        else $error("first identifier write not taken");

    // Captured mode must not drift once known, or the base default would flip
    a_strap_held: assert property (gfx_known_ff |=> // [RULE3]
        gfx_known_ff && $stable(integrated_graphics_mode_ff))
        else $error("graphics mode changed after capture");

endmodule

//--- hbcfg_regs_bench.sv
`timescale 1ns/1ps
module hbcfg_regs_bench
    import hbcfg_pkg::*;
;
    // ---------------------------------------------------------
    // Stimulus, model state and counters
    // ---------------------------------------------------------
    logic clk;
    logic resetn;
    logic size;
    logic en;
    logic strap;
    logic mreq;
    logic [31:0] maddr;
    hbcfg_req_s req;
    logic [31:0] rdata;
    logic rvalid;
    logic hit;
    logic [31:0] seed;
    logic [31:0] v;
    logic [31:0] d;
    logic [3:0] be;
    int upper, b25, subsystem_maker_ident, locked, gfx, fails, n_tests;

    // Device under test, every input driven
    hbcfg_regs i_hbcfg_regs (
        .CLK(clk),
        .RESETN(resetn),
        .CFG_REQ(req),
        .CFG_RDATA(rdata),
        .CFG_RVALID(rvalid),
        .APER_SIZE_CTRL(size),
        .APER_ACCESS_EN(en),
        .INTEGRATED_GRAPHICS_MODE_STRAP(strap),
        .MEM_REQ(mreq),
        .MEM_ADDR(maddr),
        .APER_HIT(hit)
    );

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ---------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected aperture base as software should read it
    function automatic logic [31:0] ap_exp();
        if (gfx != 0)
        begin
            return 32'h00000000;
        end
        return (32'(upper) << 26) | (32'(b25 & int'(size)) << 25) | 32'h00000008;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && n_tests > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Strap is held through reset, so the capture sees a stable level
    task automatic do_reset(input logic g);
        resetn = 1'b0;
        strap = g;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        upper = 0; b25 = 0; subsystem_maker_ident = 0; locked = 0; gfx = int'(g);
    endtask

    // Bus tasks start and end one step after a rising edge
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
        req.wr = 1'b1; req.addr = a; req.be = b; req.wdata = w;
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask

    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] r);
        req.rd = 1'b1; req.addr = a; req.be = 4'hf;
        @(posedge clk);
        #1 req.rd = 1'b0;
        chk({31'h0, rvalid}, 32'h1);
        r = rdata;
    endtask

    // One quiet cycle so a strobe is never dropped and raised in one step
    task automatic idle();
        @(posedge clk);
        #1;
    endtask

    // Hit answer stands in the cycle after the request edge
    task automatic mem_chk(input logic [31:0] a);
        logic e;
        e = en && (a[31:26] == 6'(upper)) && (!size || (int'(a[25]) == b25));
        mreq = 1'b1; maddr = a;
        @(posedge clk);
        #1 mreq = 1'b0;
        chk({31'h0, hit}, {31'h0, e});
    endtask

    // ---------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------
    initial
    begin
        seed = 32'd25416; fails = 0; n_tests = 0;
        req = '0; size = 1'b0; en = 1'b0; mreq = 1'b0; maddr = 32'h0; strap = 1'b0;
        resetn = 1'b0;
        do_reset(1'b0);
        cfg_rd(8'h10, d); chk(d, 32'h00000008);
        idle();
        cfg_rd(8'h2c, d); chk({16'h0, d[15:0]}, 32'h0);
        idle();
        cfg_rd(8'h20, d); chk(d, 32'h0);
        // Latency and header bytes shrug off an all-ones write
        cfg_wr(8'h0c, 4'hf, 32'hffffffff);
        cfg_rd(8'h0c, d); chk(d, 32'h0);
        // Random base writes with the size control toggling underneath
        for (int i = 0; i < 24; i++)
        begin
            size = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : xs() & 1;
            if (!size) b25 = 0;
            v = (i < 2) ? 32'hffffffff : xs();
            be = (i < 2) ? 4'hf : xs() & 4'hf;
            cfg_wr(8'h10, be, v);
            if (be[3]) upper = int'(v[31:26]);
            if (be[3] && size) b25 = int'(v[25]);
            cfg_rd(8'h10, d); chk(d, ap_exp());
            en = xs() & 1;
            v = xs();
            if (v[1]) v[31:25] = {6'(upper), 1'(b25)};
            mem_chk(v);
        end
        // Identifier takes the first write only
        v = xs();
        cfg_wr(8'h2c, 4'h3, v);
        cfg_rd(8'h2c, d); chk({16'h0, d[15:0]}, {16'h0, v[15:0]});
        cfg_wr(8'h2c, 4'h3, ~v);
        cfg_rd(8'h2c, d); chk({16'h0, d[15:0]}, {16'h0, v[15:0]});
        // Second reset in graphics mode clears the lock
        do_reset(1'b1);
        cfg_rd(8'h10, d); chk(d, 32'h00000000);
        idle();
        cfg_rd(8'h2c, d); chk({16'h0, d[15:0]}, 32'h0);
        cfg_wr(8'h2c, 4'h2, v);
        idle();
        cfg_wr(8'h2c, 4'h1, v);
        cfg_rd(8'h2c, d); chk({16'h0, d[15:0]}, {16'h0, v[15:8], 8'h00});
        end_sim();
    end

    // Watchdog at 5000 cycles, well beyond the 110 or so cycles the run needs
    initial
    begin
        #(50 * 5000);
        fails++;
        end_sim();
    end
endmodule
